// [hw/vss_top.sv]
// vss_top: start-up sequencer, reference setpoint ramp, voltage code decode
// and light-load gate control, with an apb register slave
// assumes pins synchronous to sys_clk, pwm_cycle one pulse per switching cycle
//
// The APB interface to the registers and the register addresses were decided locally.
`timescale 1ns/100ps
`include "vss_regs.svh"

// Summary of operation
// - start only with supply good and the regulator-on request high.
// - processor mode ramps setpoint to 1.1 V boot level at 2.5 mV/us.
// - processor mode grants clock permission after 13 in-band cycles at boot.
// - after clock permission, slew boot level to coded level at 5 mV/us.
// - processor mode raises output good about 7 ms after start.
// - start waits 120 us after supply crosses its threshold.
// - graphics mode ramps straight to the coded level, no boot level.
// - graphics ramp at base rate, doubled while deeper sleep is requested.
// - graphics mode grants clock permission after 13 in-band cycles, then good.
// - code zero gives 1.5 V, each increment lowers target by 12.5 mV.
// - light-load mode turns low-side gate off at switch-node zero.
// - light-load mode clamps ripple signal to stretch the period, except in idle.
module vss_top #(
    parameter int POR_DELAY_US = `VSS_POR_DELAY_US,
    parameter int GOOD_DELAY_US = `VSS_GOOD_DELAY_US,
    parameter int TICK_CYC = `VSS_TICK_CYC,
    parameter int BAND_CYCLES = `VSS_BAND_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire vss_pkg::vss_pins_in_type pins_in,
    output vss_pkg::vss_pins_out_type pins_out,
    output logic irq
);
    import vss_pkg::*;

    // setpoint change per tick in lsbs: the boot ramp moves at half the
    // slew step, and the graphics ramp may double the slew step
    localparam logic [11:0] STEP_BOOT =
        12'(`VSS_RATE_BOOT_UVUS / `VSS_LSB_UV);
    localparam logic [11:0] STEP_SLEW =
        12'(`VSS_RATE_SLEW_UVUS / `VSS_LSB_UV);
    // delays are counted in ticks of one microsecond, not in clocks
    localparam logic [15:0] TICK_LAST = 16'(TICK_CYC - 1);
    localparam logic [15:0] POR_TICKS = 16'(POR_DELAY_US);
    localparam logic [15:0] GOOD_TICKS = 16'(GOOD_DELAY_US);
    localparam logic [3:0] BAND_LAST = 4'(BAND_CYCLES - 1);

    // every flop of the block except the rst_sync pair lives in this one record
    typedef struct packed {
        vss_state_type state;
        logic [15:0] tick_cnt;
        logic [15:0] por_cnt;
        logic por_done;
        logic [15:0] good_cnt;
        logic [3:0] band_cnt;
        logic [11:0] setpoint;
        logic clock_permit_n;
        logic output_good;
        logic gate;
        logic gate_off;
        logic clamp;
        logic ctrl_en;
        logic [`VSS_IRQ_W-1:0] irq_stat;
        logic [`VSS_IRQ_W-1:0] irq_mask;
        logic [31:0] rdata;
        logic slverr;
    } vss_state_rec_type;

    // reset copy, record and combinational helpers
    logic [1:0] rst_sync;
    logic rst_n_s;
    vss_state_rec_type r;
    vss_state_rec_type nxt;
    logic tick;
    logic active;
    logic [11:0] target;
    logic [11:0] goal;
    logic [11:0] step;
    logic [11:0] code_drop;
    logic [`VSS_IRQ_W-1:0] events;
    logic wr_acc;
    logic rd_setup;

    // reset release through two flops; assertion still acts at once, but
    // the release is retimed so no flop leaves reset on a metastable edge
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rst_sync <= 2'b00;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n_s = rst_sync[1];

    // voltage code decode, saturating at zero for the top codes
    // codes above 120 would wrap below zero, so codes from 120 up pin the target low
    assign code_drop = 12'(pins_in.voltage_code_in) * `VSS_CODE_STEP;
    assign target = (code_drop >= `VSS_CODE_TOP) ? 12'h000 :
        (`VSS_CODE_TOP - code_drop);

    // one-cycle tick enable; the delay counters and the setpoint ramp run off it
    assign tick = (r.tick_cnt == TICK_LAST);
    assign active = pins_in.supply_ok && pins_in.regulator_on_request &&
        r.ctrl_en;
    assign wr_acc = psel && penable && pwrite;
    assign rd_setup = psel && !penable;
    // no wait states: read data is ready from the access cycle on
    assign pready = 1'b1;

    // ramp goal and step per tick for the current phase
    // processor mode aims at the boot level first; graphics goes straight on
    always_comb begin
        goal = target;
        step = STEP_SLEW;
        if (r.state == VSS_RAMP || r.state == VSS_HOLD) begin
            if (pins_in.gpu_mode) begin
                goal = target;
                step = pins_in.deeper_sleep_request ?
                    12'(STEP_SLEW << 1) : STEP_SLEW;
            end else begin
                goal = `VSS_BOOT_LEVEL;
                step = STEP_BOOT;
            end
        end
    end

    // next state of the whole block
    always_comb begin
        nxt = r;
        events = '0;

        // time base: one enable pulse per microsecond
        // TICK_CYC clocks per tick, so the rates scale with the clock
        nxt.tick_cnt = tick ? 16'h0000 : r.tick_cnt + 16'h0001;

        // delay after supply rises before any start
        // a supply dip clears the count, so a brown-out waits the full delay
        if (!pins_in.supply_ok) begin
            nxt.por_cnt = 16'h0000;
            nxt.por_done = 1'b0;
        end else if (tick && !r.por_done) begin
            if (r.por_cnt == POR_TICKS - 16'h0001) begin
                nxt.por_done = 1'b1;
            end else begin
                nxt.por_cnt = r.por_cnt + 16'h0001;
            end
        end

        // setpoint slews toward the goal, one step per tick
        // the last step is trimmed so the setpoint lands exactly on the goal
        if (r.state != VSS_IDLE && tick) begin
            if (r.setpoint < goal) begin
                nxt.setpoint = (goal - r.setpoint > step) ?
                    r.setpoint + step : goal;
            end else if (r.setpoint > goal) begin
                nxt.setpoint = (r.setpoint - goal > step) ?
                    r.setpoint - step : goal;
            end
        end

        // output good timer runs from the start of the sequence
        // it stops at the limit, so a long regulate phase cannot wrap it
        if (r.state != VSS_IDLE && tick && r.good_cnt != GOOD_TICKS) begin
            nxt.good_cnt = r.good_cnt + 16'h0001;
        end

        // sequencer
        case (r.state)
            VSS_IDLE: begin
                // clear the counters so every start counts afresh
                nxt.band_cnt = 4'h0;
                nxt.good_cnt = 16'h0000;
                if (active && r.por_done) begin
                    nxt.state = VSS_RAMP;
                end
            end
            VSS_RAMP: begin
                // the hold count starts only once the goal is reached
                if (r.setpoint == goal) begin
                    nxt.state = VSS_HOLD;
                    nxt.band_cnt = 4'h0;
                end
            end
            VSS_HOLD: begin
                // one out-of-band cycle anywhere restarts the whole count
                if (!pins_in.vout_in_band) begin
                    nxt.band_cnt = 4'h0;
                end else if (pins_in.pwm_cycle) begin
                    if (r.band_cnt == BAND_LAST) begin
                        nxt.clock_permit_n = 1'b0;
                        events[`VSS_IRQ_CLKPERM_BIT] = 1'b1;
                        nxt.state = pins_in.gpu_mode ? VSS_REG : VSS_SLEW;
                    end else begin
                        nxt.band_cnt = r.band_cnt + 4'h1;
                    end
                end
            end
            VSS_SLEW: begin
                // processor mode only: boot level on to the coded level
                if (r.setpoint == target) begin
                    nxt.state = VSS_REG;
                end
            end
            VSS_REG: begin
                // code changes are followed through the slew logic above
                nxt.state = VSS_REG;
            end
            default: begin
                // an unused code recovers through idle
                nxt.state = VSS_IDLE;
            end
        endcase

        // output good once permission is given and the delay ran out
        // waiting for permission keeps good from ever leading the grant
        if (!r.clock_permit_n && r.good_cnt == GOOD_TICKS &&
            !r.output_good && r.state != VSS_IDLE) begin
            nxt.output_good = 1'b1;
            events[`VSS_IRQ_GOOD_BIT] = 1'b1;
        end

        // any loss of request or supply drops back to idle
        // it comes last so it overrides a grant or good in the same cycle
        if (!active && r.state != VSS_IDLE) begin
            nxt.state = VSS_IDLE;
            nxt.clock_permit_n = 1'b1;
            nxt.output_good = 1'b0;
            nxt.setpoint = `VSS_SP_RESET;
            events[`VSS_IRQ_DROP_BIT] = 1'b1;
        end

        // light-load mode: hold low side off after the zero crossing
        // the latch keeps the gate off for the rest of the pulse, so
        // ringing on the switch node cannot turn it back on too early
        if (!pins_in.low_side_cmd) begin
            nxt.gate_off = 1'b0;
        end else if (pins_in.reverse_block_mode &&
            pins_in.switch_node_zero) begin
            nxt.gate_off = 1'b1;
        end
        nxt.gate = pins_in.low_side_cmd && !(pins_in.reverse_block_mode &&
            (pins_in.switch_node_zero || r.gate_off));
        nxt.clamp = pins_in.reverse_block_mode &&
            (r.state != VSS_IDLE);

        // register writes; interrupt bits are write one to clear
        // read-only and unmapped offsets leave every register unchanged
        if (wr_acc) begin
            case (paddr)
                `VSS_OFF_CTRL: begin
                    nxt.ctrl_en = pwdata[`VSS_CTRL_EN_BIT];
                end
                `VSS_OFF_IRQ_STAT: begin
                    nxt.irq_stat = r.irq_stat & ~pwdata[`VSS_IRQ_W-1:0];
                end
                `VSS_OFF_IRQ_MASK: begin
                    nxt.irq_mask = pwdata[`VSS_IRQ_W-1:0];
                end
                default: begin
                    nxt.irq_mask = r.irq_mask;
                end
            endcase
        end
        // a new event wins over a clear in the same cycle
        nxt.irq_stat = nxt.irq_stat | events;

        // read data and error are captured in the setup cycle
        // so prdata comes from a flop and pready can stay high throughout;
        // unmapped offsets read zero and raise pslverr in the access phase
        if (rd_setup) begin
            nxt.rdata = 32'h0000_0000;
            nxt.slverr = 1'b0;
            case (paddr)
                `VSS_OFF_CTRL: begin
                    nxt.rdata[`VSS_CTRL_EN_BIT] = r.ctrl_en;
                end
                `VSS_OFF_STATUS: begin
                    nxt.rdata[`VSS_ST_STATE_LSB +: 3] = r.state;
                    nxt.rdata[`VSS_ST_CLKPERM_BIT] = !r.clock_permit_n;
                    nxt.rdata[`VSS_ST_GOOD_BIT] = r.output_good;
                    nxt.rdata[`VSS_ST_GPU_BIT] = pins_in.gpu_mode;
                    nxt.rdata[`VSS_ST_BAND_LSB +: 4] = r.band_cnt;
                end
                `VSS_OFF_IRQ_STAT: begin
                    nxt.rdata[`VSS_IRQ_W-1:0] = r.irq_stat;
                end
                `VSS_OFF_IRQ_MASK: begin
                    nxt.rdata[`VSS_IRQ_W-1:0] = r.irq_mask;
                end
                `VSS_OFF_SETPOINT: begin
                    nxt.rdata[11:0] = r.setpoint;
                end
                default: begin
                    nxt.slverr = 1'b1;
                end
            endcase
        end
    end

    // single state register
    // the reset branch holds constants only; the release is already retimed
    always_ff @(posedge sys_clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            r.state <= VSS_IDLE;
            r.tick_cnt <= 16'h0000;
            r.por_cnt <= 16'h0000;
            r.por_done <= 1'b0;
            r.good_cnt <= 16'h0000;
            r.band_cnt <= 4'h0;
            r.setpoint <= `VSS_SP_RESET;
            r.clock_permit_n <= 1'b1;
            r.output_good <= 1'b0;
            r.gate <= 1'b0;
            r.gate_off <= 1'b0;
            r.clamp <= 1'b0;
            r.ctrl_en <= `VSS_CTRL_RESET;
            r.irq_stat <= '0;
            r.irq_mask <= `VSS_IRQ_MASK_RESET;
            r.rdata <= 32'h0000_0000;
            r.slverr <= 1'b0;
        end else begin
            r <= nxt;
        end
    end

    // outputs straight from the state register
    // irq is a level, high while any unmasked sticky bit stands
    assign prdata = r.rdata;
    assign pslverr = r.slverr;
    assign irq = |(r.irq_stat & r.irq_mask);
    assign pins_out.setpoint = r.setpoint;
    assign pins_out.clock_permit_n = r.clock_permit_n;
    assign pins_out.output_good_flag = r.output_good;
    assign pins_out.low_side_gate_drive = r.gate;
    assign pins_out.ripple_clamp = r.clamp;

endmodule

// [common/vss_regs.svh]
// vss_regs.svh: register offsets, field positions, reset values and timing
// figures of the start-up sequencer; assumes a 32-bit apb slave, 50 mhz clock
`ifndef VSS_REGS_SVH
`define VSS_REGS_SVH

// register byte offsets
`define VSS_OFF_CTRL 12'h000
`define VSS_OFF_STATUS 12'h004
`define VSS_OFF_IRQ_STAT 12'h008
`define VSS_OFF_IRQ_MASK 12'h00c
`define VSS_OFF_SETPOINT 12'h010

// control register fields
`define VSS_CTRL_EN_BIT 0
`define VSS_CTRL_RESET 1'b1

// status register fields
`define VSS_ST_STATE_LSB 0
`define VSS_ST_CLKPERM_BIT 4
`define VSS_ST_GOOD_BIT 5
`define VSS_ST_GPU_BIT 6
`define VSS_ST_BAND_LSB 8

// interrupt status and mask fields
`define VSS_IRQ_W 3
`define VSS_IRQ_CLKPERM_BIT 0
`define VSS_IRQ_GOOD_BIT 1
`define VSS_IRQ_DROP_BIT 2
`define VSS_IRQ_MASK_RESET 3'h0

// setpoint scale: one lsb is 500 uV, so 1.5 V is 3000
`define VSS_LSB_UV 500
`define VSS_CODE_TOP 12'hbb8
`define VSS_CODE_STEP 12'h019
`define VSS_BOOT_LEVEL 12'h898
`define VSS_SP_RESET 12'h000

// slew rates in uV per us
`define VSS_RATE_BOOT_UVUS 2500
`define VSS_RATE_SLEW_UVUS 5000

// time base
`define VSS_CLK_NS 20
`define VSS_TICK_NS 1000
`define VSS_TICK_CYC (`VSS_TICK_NS / `VSS_CLK_NS)

// in-band switching cycles before clock permission
`define VSS_BAND_CYCLES 13

// start delay after supply good, and output-good delay, in us
`define VSS_POR_DELAY_US 120
`define VSS_GOOD_DELAY_US 7000

`endif

// [common/vss_pkg.sv]
// vss_pkg: types shared by the start-up sequencer and its surroundings
// assumes vss_regs.svh holds every number
package vss_pkg;

    // sequencer states, gray coded along the processor start-up path
    typedef enum logic [2:0] {
        VSS_IDLE = 3'b000,
        VSS_RAMP = 3'b001,
        VSS_HOLD = 3'b011,
        VSS_SLEW = 3'b010,
        VSS_REG = 3'b110
    } vss_state_type;

    // control pins from the processor and the analog front end
    typedef struct packed {
        logic supply_ok;
        logic regulator_on_request;
        logic gpu_mode;
        logic deeper_sleep_request;
        logic [6:0] voltage_code_in;
        logic pwm_cycle;
        logic vout_in_band;
        logic reverse_block_mode;
        logic switch_node_zero;
        logic low_side_cmd;
    } vss_pins_in_type;

    // outputs toward the modulator, drivers and system
    typedef struct packed {
        logic [11:0] setpoint;
        logic clock_permit_n;
        logic output_good_flag;
        logic low_side_gate_drive;
        logic ripple_clamp;
    } vss_pins_out_type;

endpackage

// [verif/vss_chk_sva.sv]
// vss_chk_sva: pin-level checks of the start-up sequencer outputs
// assumes it is bound onto vss_top; sys_clk rising edge, rstn active low
`timescale 1ns/100ps
module vss_chk_sva (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire vss_pkg::vss_pins_in_type pins_in,
    input wire vss_pkg::vss_pins_out_type pins_out
);
    import vss_pkg::*;
    // the design leaves reset two edges after rstn rises and updates one
    // edge later, so the checks wait three edges after each release
    logic [2:0] rst_hold_r;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rst_hold_r <= 3'h0;
        end else begin
            rst_hold_r <= {rst_hold_r[1:0], 1'b1};
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_hold_r[2]);

    // loss of supply or request returns permission, good and setpoint to idle in one edge
    property p_drop;
        (!pins_in.supply_ok || !pins_in.regulator_on_request)
        |=> pins_out.clock_permit_n && !pins_out.output_good_flag
        && pins_out.setpoint == 12'h000;
    endproperty
    a_drop: assert property (p_drop)
        else $error("sequencer not idle after drop");
    // output good never stands without clock permission
    property p_good_perm;
        pins_out.output_good_flag |-> !pins_out.clock_permit_n;
    endproperty
    a_good_perm: assert property (p_good_perm)
        else $error("output good without permission");
    // except on a move to or from zero, the reference never moves more than the doubled ramp step per clock
    property p_step;
        (pins_out.setpoint != 12'h000 && $past(pins_out.setpoint) != 12'h000)
        |-> pins_out.setpoint <= $past(pins_out.setpoint) + 12'h014
        && $past(pins_out.setpoint) <= pins_out.setpoint + 12'h014;
    endproperty
    a_step: assert property (p_step)
        else $error("setpoint jumped");
    property p_sp_top;
        pins_out.setpoint <= 12'hbb8;
    endproperty
    a_sp_top: assert property (p_sp_top)
        else $error("setpoint above top code");
    property p_gate_zero;
        pins_in.reverse_block_mode && pins_in.switch_node_zero
        |=> !pins_out.low_side_gate_drive;
    endproperty
    a_gate_zero: assert property (p_gate_zero)
        else $error("low side on past zero crossing");
    property p_gate_pass;
        !pins_in.reverse_block_mode
        |=> pins_out.low_side_gate_drive == $past(pins_in.low_side_cmd);
    endproperty
    a_gate_pass: assert property (p_gate_pass)
        else $error("low side does not follow command");
    property p_clamp;
        pins_out.ripple_clamp |-> $past(pins_in.reverse_block_mode);
    endproperty
    a_clamp: assert property (p_clamp)
        else $error("ripple clamp outside light-load mode");
    // permission is only granted while the output sits in band
    property p_perm_band;
        $fell(pins_out.clock_permit_n) |-> $past(pins_in.vout_in_band);
    endproperty
    a_perm_band: assert property (p_perm_band)
        else $error("permission granted out of band");
    property p_perm_stand;
        !pins_out.clock_permit_n && pins_in.supply_ok
        && pins_in.regulator_on_request |=> !pins_out.clock_permit_n;
    endproperty
    a_perm_stand: assert property (p_perm_stand)
        else $error("permission released while active");
endmodule

bind vss_top vss_chk_sva i_chk (.sys_clk(sys_clk), .rstn(rstn),
    .pins_in(pins_in), .pins_out(pins_out));

// [verif/vss_sys_model.sv]
// vss_sys_model: switching-cycle pulses and output band flag
// assumes sys_clk rising edge; band_ok is set by the bench
`timescale 1ns/100ps
module vss_sys_model (
    input wire logic sys_clk,
    input wire logic band_ok,
    output logic pwm_cycle,
    output logic vout_in_band
);
    logic [2:0] div_r = 3'h0;
    // one switching pulse every eight clocks, band follows one clock late
    always @(posedge sys_clk) begin
        div_r <= div_r + 3'h1;
        pwm_cycle <= (div_r == 3'h7);
        vout_in_band <= band_ok;
    end
endmodule

// [verif/vss_top_tb.sv]
// vss_top_tb: apb and pin sequences for the start-up sequencer
// assumes short delay parameters, bound checker and the switching model
`timescale 1ns/100ps
`include "vss_regs.svh"
module vss_top_tb;
    import vss_pkg::*;
    localparam int TK = 2;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, irq, pwm, inb;
    logic band_ok = 1'b1;
    vss_pins_in_type drv = '0;
    vss_pins_in_type pins_in;
    vss_pins_out_type po;
    logic [6:0] codes [6] = '{7'h01, 7'h08, 7'h40, 7'h77, 7'h78, 7'h7f};
    logic [3:0] gtab [6] = '{4'hb, 4'he, 4'ha, 4'h8, 4'hb, 4'h7};
    int bad_count = 0;
    int samples_checked = 0;
    int n;
    // model outputs merged into the pin struct
    always_comb begin
        pins_in = drv;
        pins_in.pwm_cycle = pwm;
        pins_in.vout_in_band = inb;
    end
    vss_top #(.POR_DELAY_US(2), .GOOD_DELAY_US(20), .TICK_CYC(TK),
        .BAND_CYCLES(13)) i_dut (.sys_clk(sys_clk), .rstn(rstn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pins_in(pins_in), .pins_out(po), .irq(irq));
    vss_sys_model i_sys (.sys_clk(sys_clk), .band_ok(band_ok),
        .pwm_cycle(pwm), .vout_in_band(inb));
    initial begin
        forever #10 sys_clk = ~sys_clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
        input string msg);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask
    // one apb transfer; d is write data or expected read data under m
    task automatic xfer(input logic w, input logic [11:0] a,
        input logic [31:0] d, input logic [31:0] m, input logic e);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1) @(posedge sys_clk);
        if (!w) chk(prdata & m, d & m, "read data");
        chk(pslverr, e, "slave error");
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_sp(input logic [11:0] v);
        n = 0;
        while (po.setpoint !== v && n < 4000) begin
            @(posedge sys_clk);
            n++;
        end
        chk(po.setpoint, v, "setpoint");
    endtask
    task automatic wait_move();
        n = 0;
        while (po.setpoint === 12'h000 && n < 4000) begin
            @(posedge sys_clk);
            n++;
        end
    endtask
    // bit 3 of the out struct is permission, bit 2 output good
    task automatic wait_pin(input int s, input logic v);
        n = 0;
        while (po[s] !== v && n < 4000) begin
            @(posedge sys_clk);
            n++;
        end
        chk(po[s], v, "pin level");
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge sys_clk);
        rstn <= 1'b1;
        repeat (4) @(posedge sys_clk);
        xfer(0, `VSS_OFF_CTRL, 32'h1, 32'h1, 0);
        xfer(0, `VSS_OFF_IRQ_MASK, 32'h0, 32'h7, 0);
        xfer(0, `VSS_OFF_STATUS, 32'h0, 32'h7f, 0);
        xfer(0, 12'h020, 32'h0, 32'hffffffff, 1);
        xfer(1, 12'h020, 32'h5, 32'h0, 1);
        $display("test registers done");
        drv.regulator_on_request <= 1'b1;
        repeat (300) @(posedge sys_clk);
        chk(po.setpoint, 12'h000, "no start without supply");
        drv.supply_ok <= 1'b1;
        wait_move();
        chk(n >= 3 * TK, 1'b1, "start delay");
        chk(po.setpoint, 12'h005, "first boot step");
        wait_sp(12'h898);
        repeat (40) @(posedge sys_clk);
        band_ok <= 1'b0;
        repeat (24) @(posedge sys_clk);
        xfer(0, `VSS_OFF_STATUS, 32'h003, 32'hf17, 0);
        band_ok <= 1'b1;
        wait_pin(3, 1'b0);
        chk(po.setpoint, 12'h898, "boot level held");
        wait_sp(12'hbb8);
        xfer(0, `VSS_OFF_SETPOINT, 32'hbb8, 32'hfff, 0);
        wait_pin(2, 1'b1);
        xfer(0, `VSS_OFF_STATUS, 32'h36, 32'h7f, 0);
        $display("test processor start done");
        foreach (codes[i]) begin
            drv.voltage_code_in <= codes[i];
            wait_sp(codes[i] >= 7'h78 ? 12'h000 :
                12'hbb8 - 12'h019 * {5'h00, codes[i]});
        end
        $display("test code table done");
        xfer(1, `VSS_OFF_IRQ_MASK, 32'h7, 32'h0, 0);
        xfer(0, `VSS_OFF_IRQ_STAT, 32'h3, 32'h3, 0);
        chk(irq, 1'b1, "irq raised");
        xfer(1, `VSS_OFF_IRQ_MASK, 32'h0, 32'h0, 0);
        @(posedge sys_clk);
        chk(irq, 1'b0, "irq masked");
        xfer(1, `VSS_OFF_IRQ_STAT, 32'h3, 32'h0, 0);
        xfer(0, `VSS_OFF_IRQ_STAT, 32'h0, 32'h3, 0);
        xfer(1, `VSS_OFF_IRQ_MASK, 32'h4, 32'h0, 0);
        drv.regulator_on_request <= 1'b0;
        repeat (3) @(posedge sys_clk);
        chk({irq, po.clock_permit_n, po.output_good_flag}, 3'b110,
            "drop to idle");
        xfer(1, `VSS_OFF_IRQ_STAT, 32'h7, 32'h0, 0);
        @(posedge sys_clk);
        chk(irq, 1'b0, "irq cleared");
        $display("test interrupts done");
        drv.gpu_mode <= 1'b1;
        drv.voltage_code_in <= 7'h08;
        for (int d = 0; d < 2; d++) begin
            drv.deeper_sleep_request <= d[0];
            drv.regulator_on_request <= 1'b1;
            wait_move();
            chk(po.setpoint, 12'h00a << d, "graphics step");
            wait_pin(3, 1'b0);
            chk(po.setpoint, 12'haf0, "direct to target");
            wait_pin(2, 1'b1);
            @(posedge sys_clk);
            drv.regulator_on_request <= 1'b0;
            repeat (3) @(posedge sys_clk);
        end
        $display("test graphics start done");
        drv.regulator_on_request <= 1'b1;
        foreach (gtab[i]) begin
            drv.reverse_block_mode <= gtab[i][3];
            drv.switch_node_zero <= gtab[i][2];
            drv.low_side_cmd <= gtab[i][1];
            repeat (4) @(posedge sys_clk);
            chk(po.low_side_gate_drive, gtab[i][0], "gate");
            chk(po.ripple_clamp, gtab[i][3], "clamp");
        end
        $display("test light load done");
        xfer(1, `VSS_OFF_CTRL, 32'h0, 32'h0, 0);
        xfer(0, `VSS_OFF_STATUS, 32'h0, 32'h7, 0);
        chk(po.setpoint, 12'h000, "disabled to idle");
        drv.low_side_cmd <= 1'b0;
        rstn <= 1'b0;
        repeat (2) @(posedge sys_clk);
        chk({irq, po}, 17'h00008, "reset values");
        rstn <= 1'b1;
        repeat (2) @(posedge sys_clk);
        chk({irq, po}, 17'h00008, "held after release");
        wait_move();
        chk(n >= 3 * TK, 1'b1, "restart delay");
        $display("test disable and reset done");
        tally_and_finish();
    end
    // watchdog far beyond the expected run length
    initial begin
        repeat (60000) @(posedge sys_clk);
        bad_count++;
        tally_and_finish();
    end
endmodule
